// ---- inc/rsd_pkg.sv ----
package rsd_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;      // System clock rate
    localparam int STEP_MS = 1000;           // Status array dwell, ms
    localparam int STEP_CYC = (CLK_HZ / 1000) * STEP_MS;
    localparam int HUNT_US = 1000;           // Dwell per hunted rate, us
    localparam int HUNT_CYC = (CLK_HZ / 1_000_000) * HUNT_US;
    localparam int STEP_CW = 25;             // Holds STEP_CYC
    localparam int HUNT_CW = 20;             // Holds HUNT_CYC
    localparam int NCH = 8;                  // Channels per card

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_DISPLAY = 8'h08;
    localparam logic [7:0] REG_RATES = 8'h0c;

    // Control fields
    localparam int CTRL_BYP_LSB = 0;         // Software bypass mask
    localparam int CTRL_FREEZE_BIT = 8;      // Hold display on channel
    localparam logic [8:0] CTRL_RST = 9'h000;

    // Status fields
    localparam int STAT_LOCK_LSB = 0;
    localparam int STAT_PG_BIT = 8;
    localparam int STAT_FAULT_BIT = 9;
    localparam int STAT_SW_LSB = 16;

    // Display fields
    localparam int DISP_ARRAY_LSB = 0;
    localparam int DISP_IDX_LSB = 8;

    // ------------------------------------------------------------
    // Rate codes and fixed patterns
    // ------------------------------------------------------------
    localparam logic [2:0] RATE_NONE = 3'h0;
    localparam logic [2:0] RATE_270M = 3'h2;
    localparam logic [2:0] RATE_360M = 3'h3;
    localparam logic [2:0] RATE_540M = 3'h4;
    localparam logic [2:0] RATE_1G5 = 3'h5;
    localparam logic [7:0] FAULT_PATTERN = 8'h55;

    // Card variants sharing this logic
    typedef enum logic [1:0] {
        RSD_MULTIRATE,
        RSD_HD,
        RSD_3G,
        RSD_DAC
    } rsd_variant_e;

    // Per-channel reclocker states
    typedef enum logic [1:0] {
        CH_BYPASS,
        CH_HUNT,
        CH_LOCKED
    } rsd_chst_e;

endpackage

// ---- hw/rsd_chan.sv ----
`timescale 1ns/10ps
module rsd_chan #(
    parameter int HUNT_CYCLES = rsd_pkg::HUNT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bypass_i,          // 1 = bypass, from switch or software
    input wire logic carrier_i,         // Signal present
    input wire logic lock_det_i,        // Reclocker lock detect
    output logic reclock_en_o,          // 0 defeats the reclocker
    output logic [1:0] rate_sel_o,      // Rate being tried or held
    output logic locked_o,              // Holding a lock
    output logic [2:0] rate_code_o      // Display code of held rate
);
    import rsd_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rsd_chst_e st;                  // Channel state
        logic [1:0] rate;               // Index into rate list
        logic [HUNT_CW-1:0] cnt;        // Dwell on current rate
    } rsd_chan_s;

    rsd_chan_s s_r;
    rsd_chan_s s_nxt;
    logic good;

    assign good = lock_det_i & carrier_i;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        case (s_r.st)
            CH_BYPASS: begin
                // Leave bypass as soon as bypass_i says reclock
                if (!bypass_i) begin
                    s_nxt.st = CH_HUNT;
                    s_nxt.cnt = '0;
                end
            end
            CH_HUNT: begin
                if (bypass_i) begin
                    s_nxt.st = CH_BYPASS;
                end else if (good) begin
                    s_nxt.st = CH_LOCKED;
                end else if (s_r.cnt == HUNT_CW'(HUNT_CYCLES - 1)) begin
                    // No lock here, try the next of the four rates
                    s_nxt.rate = s_r.rate + 2'h1;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + HUNT_CW'(1);
                end
            end
            CH_LOCKED: begin
                if (bypass_i) begin
                    s_nxt.st = CH_BYPASS;
                end else if (!good) begin
                    // Lost lock: resume hunting from the next rate
                    s_nxt.st = CH_HUNT;
                    s_nxt.rate = s_r.rate + 2'h1;
                    s_nxt.cnt = '0;
                end
            end
            default: begin
                s_nxt.st = CH_BYPASS;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_nxt_reset_guard: begin
                s_r.st <= CH_BYPASS;
                s_r.rate <= 2'h0;
                s_r.cnt <= '0;
            end
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs, all from state flops
    // ------------------------------------------------------------
    assign reclock_en_o = (s_r.st != CH_BYPASS);
    assign rate_sel_o = s_r.rate;
    assign locked_o = (s_r.st == CH_LOCKED);

    // Rate list order: 270M, 360M, 540M, 1.485G
    always_comb begin
        rate_code_o = RATE_NONE;
        if (s_r.st == CH_LOCKED) begin
            case (s_r.rate)
                2'h0: rate_code_o = RATE_270M;
                2'h1: rate_code_o = RATE_360M;
                2'h2: rate_code_o = RATE_540M;
                default: rate_code_o = RATE_1G5;
            endcase
        end
    end

endmodule

// ---- hw/rsd_top.sv ----
// The register addresses and the Wishbone slave port are this design's own decisions.
`timescale 1ns/10ps
// What this block does
// - One lock LED per channel, eight channels
// - Lock LED dark without signal or bypassed (DAC: without signal only)
// - Power LED only when both supplies run
// - Three index LEDs show channel, MSB first
// - Three rate LEDs encode locked rate code
// - Display advances about once per second
// - Chip access fault shows 0x55 pattern
// - Reclock channels hunt four supported rates
// - Lock and retime; on loss hunt next
// - Bypass forwards data without retiming
// - Multi-rate card passes odd signals unmuted
// - 3G: switch on defeats that reclocker
// - 3G: LED lit only present and reclocked
// - DAC card: LED green when signal present
module rsd_top #(
    parameter rsd_pkg::rsd_variant_e VARIANT = rsd_pkg::RSD_MULTIRATE,
    parameter int STEP_CYCLES = rsd_pkg::STEP_CYC,
    parameter int HUNT_CYCLES = rsd_pkg::HUNT_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Board inputs
    input wire logic [rsd_pkg::NCH-1:0] reclock_bypass_switches_i,
    input wire logic [1:0] supply_ok_i,
    input wire logic chip_access_fault_i,
    input wire logic [rsd_pkg::NCH-1:0] carrier_i,
    input wire logic [rsd_pkg::NCH-1:0] lock_det_i,
    // Reclocker controls
    output logic [rsd_pkg::NCH-1:0] reclock_en_o,
    output logic [rsd_pkg::NCH*2-1:0] rate_sel_o,
    output logic [rsd_pkg::NCH-1:0] retime_o,
    // Indicators, high = lit
    output logic [rsd_pkg::NCH-1:0] channel_lock_leds_o,
    output logic power_good_led_o,
    output logic [7:0] status_array_leds_o
);
    import rsd_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic ack;                      // Bus answer
        logic [31:0] rdata;             // Read data
        logic [8:0] ctrl;               // Freeze + software bypass
        logic [STEP_CW-1:0] step_cnt;   // Display dwell divider
        logic [2:0] idx;                // Displayed channel
        logic [NCH-1:0] lock_leds;      // Lock indicators
        logic pg;                       // Power good indicator
        logic [7:0] array_leds;         // Status array
    } rsd_top_s;

    rsd_top_s s_r;
    rsd_top_s s_nxt;

    // Channel bypass and outputs; LED, step and bus terms
    logic [NCH-1:0] eff_bypass;         // Switch or software bypass
    logic [NCH-1:0] locked;
    logic [NCH*3-1:0] rate_codes;
    logic [NCH-1:0] chan_en;
    logic [NCH-1:0] lock_leds_calc;     // Variant-dependent LED term
    logic step_tick;                    // One pulse per display step
    logic bus_req;
    logic [31:0] rd_mux;
    logic [31:0] wmask;                 // Byte lanes to bits

    // ------------------------------------------------------------
    // Bypass selection
    // ------------------------------------------------------------
    // Switch bit n belongs to channel n; software may add bypasses
    // but can never override a switch that asks for bypass.
    // The DAC card has no reclocker, so every channel stays bypassed.
    always_comb begin
        if (VARIANT == RSD_DAC) begin
            eff_bypass = '1;
        end else begin
            eff_bypass = reclock_bypass_switches_i |
                         s_r.ctrl[CTRL_BYP_LSB +: NCH];
        end
    end

    // ------------------------------------------------------------
    // Reclocker channels
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < NCH; g++) begin : gen_ch
            rsd_chan #(
                .HUNT_CYCLES(HUNT_CYCLES)
            ) u_chan (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .bypass_i(eff_bypass[g]),
                .carrier_i(carrier_i[g]),
                .lock_det_i(lock_det_i[g]),
                .reclock_en_o(chan_en[g]),
                .rate_sel_o(rate_sel_o[g*2 +: 2]),
                .locked_o(locked[g]),
                .rate_code_o(rate_codes[g*3 +: 3])
            );
        end
    endgenerate

    assign reclock_en_o = chan_en;
    // Retime only while locked; otherwise the data path passes the
    // signal straight through, so odd rates are never muted.
    assign retime_o = locked & chan_en;

    // ------------------------------------------------------------
    // Lock indicator source per card variant
    // ------------------------------------------------------------
    always_comb begin
        if (VARIANT == RSD_DAC) begin
            lock_leds_calc = carrier_i;
        end else begin
            // Lit only with signal present, reclocking, and locked
            lock_leds_calc = locked & carrier_i & lock_det_i &
                             ~eff_bypass;
        end
    end

    // ------------------------------------------------------------
    // Display dwell divider
    // ------------------------------------------------------------
    assign step_tick = (s_r.step_cnt == STEP_CW'(STEP_CYCLES - 1));

    // ------------------------------------------------------------
    // Bus helpers
    // ------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~s_r.ack;
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Read mux; unmapped offsets read as zero and still answer
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (wb_adr_i == REG_CTRL) begin
            rd_mux[8:0] = s_r.ctrl;
        end else if (wb_adr_i == REG_STATUS) begin
            rd_mux[STAT_LOCK_LSB +: NCH] = s_r.lock_leds;
            rd_mux[STAT_PG_BIT] = s_r.pg;
            rd_mux[STAT_FAULT_BIT] = chip_access_fault_i;
            rd_mux[STAT_SW_LSB +: NCH] = reclock_bypass_switches_i;
        end else if (wb_adr_i == REG_DISPLAY) begin
            rd_mux[DISP_ARRAY_LSB +: 8] = s_r.array_leds;
            rd_mux[DISP_IDX_LSB +: 3] = s_r.idx;
        end else if (wb_adr_i == REG_RATES) begin
            rd_mux[NCH*3-1:0] = rate_codes;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;

        // Single-wait-state answer, dropped the cycle after
        s_nxt.ack = bus_req;
        if (bus_req) begin
            s_nxt.rdata = rd_mux;
        end

        // Control write honours byte lanes
        if (bus_req && wb_we_i && wb_adr_i == REG_CTRL) begin
            s_nxt.ctrl = (s_r.ctrl & ~wmask[8:0]) |
                         (wb_dat_i[8:0] & wmask[8:0]);
        end

        // One-second divider keeps running even when frozen
        if (step_tick) begin
            s_nxt.step_cnt = '0;
        end else begin
            s_nxt.step_cnt = s_r.step_cnt + STEP_CW'(1);
        end

        // Step the shown channel; 3-bit wrap gives 7 -> 0
        if (step_tick && !s_r.ctrl[CTRL_FREEZE_BIT]) begin
            s_nxt.idx = s_r.idx + 3'h1;
        end

        // Indicators
        s_nxt.lock_leds = lock_leds_calc;
        s_nxt.pg = supply_ok_i[0] & supply_ok_i[1];

        // Status array: fixed pattern overrides index and rate
        if (chip_access_fault_i) begin
            s_nxt.array_leds = FAULT_PATTERN;
        end else begin
            // Upper three show the index, MSB on the first LED
            s_nxt.array_leds[7:5] = s_nxt.idx;
            s_nxt.array_leds[4:3] = 2'h0;
            // Lower three show the rate, MSB on the first LED
            s_nxt.array_leds[2:0] = shown_rate_next(s_nxt.idx);
        end
    end

    // Rate code of the channel about to be shown
    function automatic logic [2:0] shown_rate_next(input logic [2:0] i);
        shown_rate_next = rate_codes[i*3 +: 3];
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_r.ack <= 1'b0;
            s_r.rdata <= 32'h0000_0000;
            s_r.ctrl <= CTRL_RST;
            s_r.step_cnt <= '0;
            s_r.idx <= 3'h0;
            s_r.lock_leds <= '0;
            s_r.pg <= 1'b0;
            s_r.array_leds <= 8'h00;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign wb_ack_o = s_r.ack;
    assign wb_dat_o = s_r.rdata;
    assign channel_lock_leds_o = s_r.lock_leds;
    assign power_good_led_o = s_r.pg;
    assign status_array_leds_o = s_r.array_leds;

endmodule

// ---- verification/rsd_top_props.sv ----
`timescale 1ns/10ps
module rsd_top_props #(
    parameter int STEP_CYCLES = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [7:0] reclock_bypass_switches_i,
    input wire logic [1:0] supply_ok_i,
    input wire logic chip_access_fault_i,
    input wire logic [7:0] carrier_i,
    input wire logic [7:0] lock_det_i,
    input wire logic [7:0] reclock_en_o,
    input wire logic [15:0] rate_sel_o,
    input wire logic [7:0] retime_o,
    input wire logic [7:0] channel_lock_leds_o,
    input wire logic power_good_led_o,
    input wire logic [7:0] status_array_leds_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [31:0] dwell_r; // Cycles the shown index has stood
    logic [2:0] idx_r;    // Index seen last cycle
    // Dwell counter; a fault hides the index, so restart
    always_ff @(posedge clk_i) begin
        idx_r <= status_array_leds_o[7:5];
        if (rst_i || chip_access_fault_i ||
            status_array_leds_o[7:5] != idx_r) begin
            dwell_r <= '0;
        end else begin
            dwell_r <= dwell_r + 32'h1;
        end
    end
    a_lock_needs_sig: assert property (
        (channel_lock_leds_o & ~$past(carrier_i & lock_det_i)) == 8'h00)
        else $error("lock lamp lit without lock");
    a_lock_dark_byp: assert property (
        (channel_lock_leds_o & ~$past(retime_o)) == 8'h00)
        else $error("lock lamp lit while not retiming");
    a_lock_follows: assert property (!$past(rst_i) |->
        ($past(retime_o & carrier_i & lock_det_i &
        ~reclock_bypass_switches_i) & ~channel_lock_leds_o) == 8'h00)
        else $error("lock lamp dark on a held lock");
    a_power_good: assert property (!$past(rst_i) |->
        power_good_led_o == &$past(supply_ok_i))
        else $error("power lamp wrong");
    a_fault_show: assert property (
        !$past(rst_i) && $past(chip_access_fault_i) |->
        status_array_leds_o == 8'h55)
        else $error("fault pattern missing");
    a_spare_dark: assert property (
        !$past(rst_i) && !$past(chip_access_fault_i) |->
        status_array_leds_o[4:3] == 2'h0)
        else $error("unused array lamps lit");
    a_index_step: assert property (
        !$past(rst_i) && !$past(chip_access_fault_i) &&
        !$past(chip_access_fault_i, 2) &&
        $changed(status_array_leds_o[7:5]) |->
        status_array_leds_o[7:5] == $past(status_array_leds_o[7:5]) + 3'h1)
        else $error("index stepped out of order");
    a_dwell_max: assert property (dwell_r <= STEP_CYCLES)
        else $error("index stalled");
    a_byp_defeat: assert property (!$past(rst_i) |->
        (reclock_en_o & $past(reclock_bypass_switches_i)) == 8'h00)
        else $error("bypassed channel still reclocking");
    // Hunting steps one rate at a time, wrapping
    for (genvar n = 0; n < 8; n++) begin : g_ch
        a_rate_step: assert property ($past(reclock_en_o[n]) &&
            reclock_en_o[n] && $changed(rate_sel_o[2*n+:2]) |->
            rate_sel_o[2*n+:2] == $past(rate_sel_o[2*n+:2]) + 2'h1)
            else $error("rate hunt out of order");
    end
endmodule
bind rsd_top rsd_top_props #(.STEP_CYCLES(STEP_CYCLES)) u_props (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reclock_bypass_switches_i(reclock_bypass_switches_i),
    .supply_ok_i(supply_ok_i),
    .chip_access_fault_i(chip_access_fault_i),
    .carrier_i(carrier_i),
    .lock_det_i(lock_det_i),
    .reclock_en_o(reclock_en_o),
    .rate_sel_o(rate_sel_o),
    .retime_o(retime_o),
    .channel_lock_leds_o(channel_lock_leds_o),
    .power_good_led_o(power_good_led_o),
    .status_array_leds_o(status_array_leds_o)
);

// ---- verification/rsd_reclk_model.sv ----
`timescale 1ns/10ps
// Reclocker chips; lock detect lags by LAT clocks
module rsd_reclk_model #(
    parameter int LAT = 2
) (
    input wire logic clk_i,
    input wire logic [7:0] reclock_en_i,
    input wire logic [15:0] rate_sel_i,
    input wire logic [7:0] carrier_i,
    input wire logic [15:0] src_rate_i, // True rate of each source
    input wire logic [7:0] std_i,       // Source rate is supported
    output logic [7:0] lock_det_o
);
    logic [7:0] hit;
    logic [7:0] pipe [LAT];
    // Locks only when tuned to a supported source rate
    always_comb begin
        for (int n = 0; n < 8; n++) begin
            hit[n] = reclock_en_i[n] & carrier_i[n] & std_i[n]
                & (rate_sel_i[2*n+:2] == src_rate_i[2*n+:2]);
        end
    end
    // Slow detector, so the hunt dwell must cover it
    always @(posedge clk_i) begin
        pipe[0] <= hit;
        for (int k = 1; k < LAT; k++) begin
            pipe[k] <= pipe[k-1];
        end
    end
    assign lock_det_o = pipe[LAT-1] & carrier_i;
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
    import rsd_pkg::*;
    localparam int STEP = 20;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rates_exp;
    logic wb_ack_o, power_good_led_o;
    logic [7:0] sw = 8'hff, car = 8'h00, std = 8'hff;
    logic [7:0] lock_det, ren, retime, leds, arr, prev_arr, exp_led;
    logic [1:0] sup = 2'h3;
    logic fault = 1'b0;
    logic [15:0] rate_sel, src = 16'h0;
    logic [2:0] code [8];
    logic [2:0] i0;
    int mismatches = 0, n_checks = 0, cycles = 0, gap = 0;
    logic [31:0] rd_q [$]; // Expected read data, oldest first
    logic [7:0] disp_q [$]; // Expected array patterns
    always #25 clk_i = ~clk_i;
    rsd_top #(.STEP_CYCLES(STEP), .HUNT_CYCLES(8)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .reclock_bypass_switches_i(sw),
        .supply_ok_i(sup), .chip_access_fault_i(fault), .carrier_i(car),
        .lock_det_i(lock_det), .reclock_en_o(ren), .rate_sel_o(rate_sel),
        .retime_o(retime), .channel_lock_leds_o(leds),
        .power_good_led_o(power_good_led_o), .status_array_leds_o(arr));
    rsd_reclk_model #(.LAT(2)) u_chips (.clk_i(clk_i),
        .reclock_en_i(ren), .rate_sel_i(rate_sel), .carrier_i(car),
        .src_rate_i(src), .std_i(std), .lock_det_o(lock_det));
    task automatic check_val(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (mismatches == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Classic cycle: hold until ack, release at that edge
    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
        rd_q.push_back(exp);
        wb(1'b0, adr, 32'h0, 4'hf);
    endtask
    // Monitor: read data on ack, array pattern on change
    always @(posedge clk_i) begin
        cycles++;
        if (wb_ack_o === 1'b1 && !wb_we_i && rd_q.size() > 0) begin
            check_val("rdata", rd_q.pop_front(), wb_dat_o);
        end
        if (arr !== prev_arr) begin
            if (disp_q.size() > 0) begin
                check_val("array", disp_q.pop_front(), arr);
                check_val("dwell", STEP, gap);
            end
            gap = 0;
        end
        gap++;
        prev_arr = arr;
        if (cycles > 3000) begin
            mismatches++;
            summarize();
        end
    end
    initial begin
        void'($urandom(83));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        // Registers: defaults, read-only, lanes, unmapped
        rd(REG_CTRL, 32'h0);
        rd(REG_STATUS, 32'h00ff0100);
        wb(1'b1, REG_STATUS, 32'hffffffff, 4'hf);
        rd(REG_STATUS, 32'h00ff0100);
        wb(1'b1, REG_CTRL, 32'h1ff, 4'h0);
        rd(REG_CTRL, 32'h0);
        wb(1'b1, REG_CTRL, 32'h1a5, 4'h1);
        rd(REG_CTRL, 32'ha5);
        wb(1'b1, REG_CTRL, 32'h0, 4'hf);
        rd(8'h10, 32'h0);
        for (int v = 0; v < 4; v++) begin
            sup <= v[1:0];
            repeat (2) @(posedge clk_i);
            check_val("pg", 32'(v == 3), 32'(power_good_led_o));
        end
        // Random rates; ch6 bypassed, ch7 odd rate reclocked
        src <= 16'($urandom());
        car <= 8'($urandom()) | 8'hc1;
        std <= 8'h7f;
        sw <= 8'h40;
        repeat (60) @(posedge clk_i);
        exp_led = car & 8'h3f;
        rates_exp = 32'h0;
        for (int n = 0; n < 8; n++) begin
            code[n] = exp_led[n] ? {1'b0, src[2*n+:2]} + 3'h2 : 3'h0;
            rates_exp[3*n+:3] = code[n];
        end
        check_val("leds", exp_led, leds);
        check_val("retime", 32'h0, {31'h0, retime[7]});
        rd(REG_RATES, rates_exp);
        // Walk the array through one full lap; own copy, no race
        i0 = arr[7:5];
        while (arr[7:5] === i0) @(posedge clk_i);
        i0 = arr[7:5];
        @(posedge clk_i);
        for (int k = 1; k < 9; k++) begin
            disp_q.push_back({i0 + 3'(k), 2'h0, code[i0 + 3'(k)]});
        end
        while (disp_q.size() > 0) @(posedge clk_i);
        // Carrier loss darkens lamp; relock after hunt
        car <= car & 8'hfe;
        repeat (3) @(posedge clk_i);
        check_val("leds", exp_led & 8'hfe, leds);
        car <= car | 8'h01;
        repeat (60) @(posedge clk_i);
        check_val("leds", exp_led, leds);
        sw <= 8'h41;
        repeat (3) @(posedge clk_i);
        check_val("reclock", 32'h0, {31'h0, ren[0]});
        check_val("leds", exp_led & 8'hfe, leds);
        // Controller cannot reach the chips
        fault <= 1'b1;
        repeat (2) @(posedge clk_i);
        check_val("array", FAULT_PATTERN, arr);
        rd(REG_STATUS, {16'h0041, 6'h0, 2'h3, exp_led & 8'hfe});
        fault <= 1'b0;
        repeat (5) @(posedge clk_i);
        summarize();
    end
endmodule
